// File: rtl/drc_pkg.sv
// Constants, register map and state type of the disturbance recorder control
package drc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRIG_SEL_OFS = 8'h04;
  localparam logic [7:0] PRE_TRIG_OFS = 8'h08;
  localparam logic [7:0] MAX_LEN_OFS = 8'h0C;
  localparam logic [7:0] REC_LEN_OFS = 8'h10;
  localparam logic [7:0] MAX_REC_OFS = 8'h14;
  localparam logic [7:0] REC_SIZE_OFS = 8'h18;
  localparam logic [7:0] CLEAR_IDX_OFS = 8'h1C;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
  localparam logic [7:0] CHAN_OFS = 8'h2C;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_FIFO_BIT = 1;
  localparam int unsigned CTRL_MANUAL_BIT = 2;
  localparam int unsigned CTRL_DIG1MS_BIT = 3;
  localparam int unsigned CTRL_ARATE_LSB = 4;
  localparam logic [1:0] ARATE_8 = 2'h1;
  localparam logic [1:0] ARATE_16 = 2'h2;

  // Status register fields
  localparam int unsigned STAT_CNT_LSB = 4;
  localparam int unsigned STAT_USED_LSB = 12;

  // Fixed binary channel positions
  localparam int unsigned CH_FALSE = 0;
  localparam int unsigned CH_TRUE = 1;
  localparam int unsigned CH_PHASE = 2;
  localparam int unsigned CH_SYNC = 3;
  localparam int unsigned CH_FAULT = 4;
  localparam int unsigned CH_FREQ = 5;
  localparam int unsigned CH_FIXED = 6;

  // Interrupt status bits
  localparam int unsigned IRQ_TRIG = 0;
  localparam int unsigned IRQ_STORED = 1;
  localparam int unsigned IRQ_FULL = 2;
  localparam int unsigned IRQ_CFG = 3;
  localparam int unsigned IRQ_W = 4;

  // Storage cap and reset values
  localparam int unsigned MAX_RECORDINGS = 100;
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] MAX_REC_RST = 7'h64;
  localparam logic [20:0] REC_LEN_RST = 21'h003E8;
  localparam logic [20:0] MAX_LEN_RST = 21'h003E8;
  localparam logic [20:0] PRE_TRIG_RST = 21'h000C8;
  localparam logic [15:0] REC_SIZE_RST = 16'h0010;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned STORE_CYC = 8;

  typedef enum logic [2:0] {
    ST_READY,
    ST_TRIGGERED,
    ST_REC_STORE,
    ST_STORING,
    ST_FULL,
    ST_CFG_ERR
  } drc_state_t;

endpackage : drc_pkg

// File: rtl/drc_recorder.sv
// Disturbance recorder control: triggers, state, storage cap, register port
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Start on manual trigger or enabled source
// - Each binary channel individually selectable as trigger
// - Never more than 100 stored recordings
// - Recording size limits how many fit
// - Disabled recorder never starts a recording
// - Status is one of six states
// - Pre-trigger above max length: config error
// - One recording with FIFO mode: config error
// - 1 ms digital with 8/16 s/c: error
// - Writing N deletes Nth recording, first is 1
// - Manual trigger returns to idle by itself
// - Constant false reads 0, constant true 1
// - Phase order channel: 0 ABC, 1 ACB
// - Sync alarm active while time sync lost
// - Internal fault channel follows unit fault
// - Frequency functions channel follows enable status
//////////////////////////////////////////////////////////////////////////////
module drc_recorder #(
  parameter int unsigned CH_W = 16,
  parameter int unsigned SZ_W = 16,
  parameter int unsigned USED_W = 20,
  parameter int unsigned MEM_BLOCKS = 4096,
  parameter int unsigned MS_CYCLES = drc_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [drc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [drc_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [drc_pkg::DATA_W-1:0] rd_data_o,
  output logic irq_o,
  output logic [2:0] rec_state_o,
  input wire logic phase_order_reversed_flag_i,
  input wire logic time_sync_lost_alarm_i,
  input wire logic internal_fault_i,
  input wire logic freq_func_enabled_i,
  input wire logic [CH_W-drc_pkg::CH_FIXED-1:0] signal_chan_i
);

  localparam int unsigned MSC_W = $clog2(MS_CYCLES + 1);
  localparam int unsigned NREC = drc_pkg::MAX_RECORDINGS;

  typedef struct packed {
    logic [drc_pkg::DATA_W-1:0] rdata;
    logic irq;
    drc_pkg::drc_state_t st;
    logic en;
    logic fifo;
    logic manual;
    logic dig1ms;
    logic [1:0] arate;
    logic [CH_W-1:0] trig_sel;
    logic [CH_W-1:0] prev_chan;
    logic [20:0] pre_trig;
    logic [20:0] max_len;
    logic [20:0] rec_len;
    logic [6:0] max_rec;
    logic [SZ_W-1:0] rec_size;
    logic [drc_pkg::CNT_W-1:0] count;
    logic [USED_W-1:0] used;
    logic [NREC-1:0][SZ_W-1:0] slots;
    logic [MSC_W-1:0] ms_cnt;
    logic [20:0] len_cnt;
    logic [3:0] st_cnt;
    logic [drc_pkg::IRQ_W-1:0] irq_stat;
    logic [drc_pkg::IRQ_W-1:0] irq_mask;
  } drc_regs_t;

  logic [1:0] rst_sync;
  logic rst_n;
  drc_regs_t s;
  drc_regs_t next_s;
  logic [CH_W-1:0] chan;
  logic [CH_W-1:0] rise;
  logic cfg_bad;
  logic [6:0] cap;
  logic room;
  logic do_clr;
  logic [drc_pkg::IRQ_W-1:0] ev;
  logic [drc_pkg::IRQ_W-1:0] w1c;
  logic [USED_W:0] need;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Binary channel set
  always_comb begin
    chan = '0;
    chan[drc_pkg::CH_FALSE] = 1'b0;
    chan[drc_pkg::CH_TRUE] = 1'b1;
    chan[drc_pkg::CH_PHASE] = phase_order_reversed_flag_i;
    chan[drc_pkg::CH_SYNC] = time_sync_lost_alarm_i;
    chan[drc_pkg::CH_FAULT] = internal_fault_i;
    chan[drc_pkg::CH_FREQ] = freq_func_enabled_i;
    chan[CH_W-1:drc_pkg::CH_FIXED] = signal_chan_i;
  end

  assign rise = chan & ~s.prev_chan & s.trig_sel;

  assign cfg_bad = (s.pre_trig > s.max_len) || (s.max_rec == 7'h01 && s.fifo) ||
                   (s.dig1ms && (s.arate == drc_pkg::ARATE_8 || s.arate == drc_pkg::ARATE_16));

  assign cap = (s.max_rec == 7'h00 || s.max_rec > drc_pkg::MAX_REC_RST) ? drc_pkg::MAX_REC_RST : s.max_rec;
  assign need = {1'b0, s.used} + (USED_W + 1)'(s.rec_size);
  assign room = ({1'b0, s.count} < {1'b0, cap}) && (need <= (USED_W + 1)'(MEM_BLOCKS));

  assign do_clr = wr_i && addr_i == drc_pkg::CLEAR_IDX_OFS && wr_data_i != '0 &&
                  wr_data_i <= {25'h0, s.count};
  assign w1c = (wr_i && addr_i == drc_pkg::IRQ_STAT_OFS) ? wr_data_i[drc_pkg::IRQ_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    ev = '0;
    next_s.rdata = '0;
    next_s.prev_chan = chan;
    next_s.manual = 1'b0;
    if (rd_i) begin
      unique case (addr_i)
        drc_pkg::CTRL_OFS: begin
          next_s.rdata[drc_pkg::CTRL_EN_BIT] = s.en;
          next_s.rdata[drc_pkg::CTRL_FIFO_BIT] = s.fifo;
          next_s.rdata[drc_pkg::CTRL_MANUAL_BIT] = s.manual;
          next_s.rdata[drc_pkg::CTRL_DIG1MS_BIT] = s.dig1ms;
          next_s.rdata[drc_pkg::CTRL_ARATE_LSB +: 2] = s.arate;
        end
        drc_pkg::TRIG_SEL_OFS: next_s.rdata[CH_W-1:0] = s.trig_sel;
        drc_pkg::PRE_TRIG_OFS: next_s.rdata[20:0] = s.pre_trig;
        drc_pkg::MAX_LEN_OFS: next_s.rdata[20:0] = s.max_len;
        drc_pkg::REC_LEN_OFS: next_s.rdata[20:0] = s.rec_len;
        drc_pkg::MAX_REC_OFS: next_s.rdata[6:0] = s.max_rec;
        drc_pkg::REC_SIZE_OFS: next_s.rdata[SZ_W-1:0] = s.rec_size;
        drc_pkg::STATUS_OFS: begin
          next_s.rdata[2:0] = s.st;
          next_s.rdata[drc_pkg::STAT_CNT_LSB +: drc_pkg::CNT_W] = s.count;
          next_s.rdata[drc_pkg::STAT_USED_LSB +: USED_W] = s.used;
        end
        drc_pkg::IRQ_STAT_OFS: next_s.rdata[drc_pkg::IRQ_W-1:0] = s.irq_stat;
        drc_pkg::IRQ_MASK_OFS: next_s.rdata[drc_pkg::IRQ_W-1:0] = s.irq_mask;
        drc_pkg::CHAN_OFS: next_s.rdata[CH_W-1:0] = chan;
        default: next_s.rdata = '0;
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        drc_pkg::CTRL_OFS: begin
          next_s.en = wr_data_i[drc_pkg::CTRL_EN_BIT];
          next_s.fifo = wr_data_i[drc_pkg::CTRL_FIFO_BIT];
          next_s.manual = wr_data_i[drc_pkg::CTRL_MANUAL_BIT];
          next_s.dig1ms = wr_data_i[drc_pkg::CTRL_DIG1MS_BIT];
          next_s.arate = wr_data_i[drc_pkg::CTRL_ARATE_LSB +: 2];
        end
        drc_pkg::TRIG_SEL_OFS: next_s.trig_sel = wr_data_i[CH_W-1:0];
        drc_pkg::PRE_TRIG_OFS: next_s.pre_trig = wr_data_i[20:0];
        drc_pkg::MAX_LEN_OFS: next_s.max_len = wr_data_i[20:0];
        drc_pkg::REC_LEN_OFS: next_s.rec_len = wr_data_i[20:0];
        drc_pkg::MAX_REC_OFS: next_s.max_rec = wr_data_i[6:0];
        drc_pkg::REC_SIZE_OFS: next_s.rec_size = wr_data_i[SZ_W-1:0];
        drc_pkg::IRQ_MASK_OFS: next_s.irq_mask = wr_data_i[drc_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    if (do_clr) begin
      next_s.used = s.used - USED_W'(s.slots[wr_data_i[6:0] - 7'h01]);
      next_s.count = s.count - 7'h01;
      for (int i = 0; i < NREC; i++) begin
        if (32'(i) + 32'h1 >= wr_data_i) begin
          next_s.slots[i] = (i < NREC - 1) ? s.slots[(i + 1) % NREC] : '0;
        end
      end
    end
    unique case (s.st)
      drc_pkg::ST_READY: begin
        if (cfg_bad) begin
          next_s.st = drc_pkg::ST_CFG_ERR;
          ev[drc_pkg::IRQ_CFG] = 1'b1;
        end else if (!room && !s.fifo) begin
          next_s.st = drc_pkg::ST_FULL;
          ev[drc_pkg::IRQ_FULL] = 1'b1;
        end else if (s.en && (s.manual || |rise)) begin
          next_s.st = drc_pkg::ST_TRIGGERED;
          ev[drc_pkg::IRQ_TRIG] = 1'b1;
        end
      end
      drc_pkg::ST_TRIGGERED: begin
        next_s.ms_cnt = '0;
        next_s.len_cnt = (s.rec_len > s.pre_trig) ? s.rec_len - s.pre_trig : 21'h000001;
        next_s.st = drc_pkg::ST_REC_STORE;
      end
      drc_pkg::ST_REC_STORE: begin
        next_s.ms_cnt = s.ms_cnt + MSC_W'(1);
        if (s.ms_cnt == MSC_W'(MS_CYCLES - 1)) begin
          next_s.ms_cnt = '0;
          next_s.len_cnt = s.len_cnt - 21'h000001;
          if (s.len_cnt == 21'h000001) begin
            next_s.st = drc_pkg::ST_STORING;
            next_s.st_cnt = '0;
          end
        end
      end
      drc_pkg::ST_STORING: begin
        next_s.st_cnt = s.st_cnt + 4'h1;
        if (s.st_cnt == 4'(drc_pkg::STORE_CYC - 1)) begin
          // Drops the oldest when out of room, in overwrite mode or not
          if (!room && next_s.count != '0) begin
            next_s.used = next_s.used - USED_W'(next_s.slots[0]);
            next_s.count = next_s.count - 7'h01;
            for (int i = 0; i < NREC; i++) begin
              next_s.slots[i] = (i < NREC - 1) ? next_s.slots[(i + 1) % NREC] : '0;
            end
          end
          if (next_s.count < cap) begin
            next_s.slots[next_s.count] = s.rec_size;
            next_s.count = next_s.count + 7'h01;
            next_s.used = next_s.used + USED_W'(s.rec_size);
          end
          ev[drc_pkg::IRQ_STORED] = 1'b1;
          next_s.st = drc_pkg::ST_READY;
        end
      end
      drc_pkg::ST_FULL: begin
        if (cfg_bad) begin
          next_s.st = drc_pkg::ST_CFG_ERR;
          ev[drc_pkg::IRQ_CFG] = 1'b1;
        end else if (room || s.fifo) begin
          next_s.st = drc_pkg::ST_READY;
        end
      end
      drc_pkg::ST_CFG_ERR: begin
        if (!cfg_bad) begin
          next_s.st = drc_pkg::ST_READY;
        end
      end
      default: next_s.st = drc_pkg::ST_READY;
    endcase
    // Event set wins over write-one clear
    next_s.irq_stat = (s.irq_stat & ~w1c) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= drc_pkg::ST_READY;
      s.pre_trig <= drc_pkg::PRE_TRIG_RST;
      s.max_len <= drc_pkg::MAX_LEN_RST;
      s.rec_len <= drc_pkg::REC_LEN_RST;
      s.max_rec <= drc_pkg::MAX_REC_RST;
      s.rec_size <= SZ_W'(drc_pkg::REC_SIZE_RST);
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rdata;
  assign irq_o = s.irq;
  assign rec_state_o = s.st;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_MANUAL_START: assert property (
    s.st == drc_pkg::ST_READY && s.manual && s.en && !cfg_bad && (room || s.fifo)
    |=> s.st == drc_pkg::ST_TRIGGERED ##1 s.st == drc_pkg::ST_REC_STORE)
    else $error("manual trigger did not start a recording");

  AST_ONLY_SELECTED: assert property (
    s.st == drc_pkg::ST_READY && !s.manual && (chan & ~s.prev_chan & s.trig_sel) == '0
    |=> s.st != drc_pkg::ST_TRIGGERED)
    else $error("recording started without a selected source");

  AST_CAP: assert property (
    s.count <= 7'(drc_pkg::MAX_RECORDINGS))
    else $error("stored count above the cap");

  AST_CAP_HOLD: assert property (
    s.count >= cap |=> s.count <= $past(s.count))
    else $error("recording stored beyond the cap");

  AST_MEM: assert property (
    s.st == drc_pkg::ST_STORING && next_s.st == drc_pkg::ST_READY && !s.fifo && s.count < cap
    && !do_clr && need <= (USED_W + 1)'(MEM_BLOCKS) |=> s.used == $past(s.used) + USED_W'($past(s.rec_size)))
    else $error("used memory not advanced by recording size");

  AST_DISABLED: assert property (
    !s.en && s.st == drc_pkg::ST_READY |=> s.st != drc_pkg::ST_TRIGGERED)
    else $error("disabled recorder started a recording");

  AST_STATE_SET: assert property (
    s.st inside {drc_pkg::ST_READY, drc_pkg::ST_TRIGGERED, drc_pkg::ST_REC_STORE,
                 drc_pkg::ST_STORING, drc_pkg::ST_FULL, drc_pkg::ST_CFG_ERR})
    else $error("illegal recorder state");

  AST_PRE_TOO_LONG: assert property (
    s.st == drc_pkg::ST_READY && s.pre_trig > s.max_len |=> s.st == drc_pkg::ST_CFG_ERR)
    else $error("long pre-trigger not flagged");

  AST_ONE_FIFO: assert property (
    s.st == drc_pkg::ST_READY && s.max_rec == 7'h01 && s.fifo |=> s.st == drc_pkg::ST_CFG_ERR)
    else $error("single recording in overwrite mode not flagged");

  AST_RATE_MIX: assert property (
    s.st == drc_pkg::ST_READY && s.dig1ms && (s.arate == 2'h1 || s.arate == 2'h2)
    |=> s.st == drc_pkg::ST_CFG_ERR ##1 s.st == drc_pkg::ST_CFG_ERR || !cfg_bad)
    else $error("sample rate mix not flagged");

  AST_CLEAR_ONE: assert property (
    do_clr && s.st != drc_pkg::ST_STORING |=> s.count == $past(s.count) - 7'h01)
    else $error("clear by index did not remove one recording");

  AST_MANUAL_IDLE: assert property (
    s.manual |=> !s.manual || $past(wr_i))
    else $error("manual trigger did not return to idle");

  AST_CONST_CH: assert property (
    chan[drc_pkg::CH_FALSE] == 1'b0 && chan[drc_pkg::CH_TRUE] == 1'b1)
    else $error("constant channels wrong");

  AST_PHASE_CH: assert property (
    chan[drc_pkg::CH_PHASE] == phase_order_reversed_flag_i)
    else $error("phase order channel wrong");

  AST_SYNC_CH: assert property (
    time_sync_lost_alarm_i |-> chan[drc_pkg::CH_SYNC])
    else $error("sync alarm channel inactive");

  AST_FAULT_CH: assert property (
    chan[drc_pkg::CH_FAULT] == internal_fault_i)
    else $error("internal fault channel wrong");

  AST_FREQ_CH: assert property (
    chan[drc_pkg::CH_FREQ] == freq_func_enabled_i)
    else $error("frequency function channel wrong");

  AST_SEQUENCE: assert property (
    s.st == drc_pkg::ST_STORING && s.st_cnt == 4'(drc_pkg::STORE_CYC - 1)
    |=> s.st == drc_pkg::ST_READY ##1 s.st inside {drc_pkg::ST_READY, drc_pkg::ST_FULL,
        drc_pkg::ST_TRIGGERED, drc_pkg::ST_CFG_ERR})
    else $error("storing did not return to ready");

endmodule // drc_recorder

// File: verification/drc_source_model.sv
// Behavioural model of the relay's internal signal sources
module drc_source_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [13:0] level_i,
  output logic phase_o,
  output logic sync_lost_o,
  output logic fault_o,
  output logic freq_en_o,
  output logic [9:0] chan_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sources change only on a clock edge or at reset, like the relay's own logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {chan_o, freq_en_o, fault_o, sync_lost_o, phase_o} <= 14'h0000;
    end else begin
      {chan_o, freq_en_o, fault_o, sync_lost_o, phase_o} <= level_i;
    end
  end
endmodule // drc_source_model

// File: verification/testbench.sv
// Self-checking bench of the disturbance recorder control
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rd_data;
  logic irq;
  logic [2:0] rec_state;
  logic [13:0] src_level = 14'h0000;
  logic phase, sync_lost, fault, freq_en;
  logic [9:0] chan;
  logic [31:0] rdv;
  int seed = 32'hd69823d2;
  int fail_count = 0;
  int tests_run = 0;
  int k;

  drc_recorder #(.MS_CYCLES(4)) drc_recorder_i (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rd_data), .irq_o(irq), .rec_state_o(rec_state),
    .phase_order_reversed_flag_i(phase), .time_sync_lost_alarm_i(sync_lost),
    .internal_fault_i(fault), .freq_func_enabled_i(freq_en), .signal_chan_i(chan)
  );
  drc_source_model drc_source_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .level_i(src_level), .phase_o(phase), .sync_lost_o(sync_lost),
    .fault_o(fault), .freq_en_o(freq_en), .chan_o(chan)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rdv = rd_data;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    `CHK("register", e, rdv)
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim && rec_state !== s; i++) begin
      @(negedge clk);
    end
    `CHK("rec_state", s, rec_state)
  endtask
  task automatic hold_state(input logic [2:0] s, input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK("rec_state held", s, rec_state)
    end
  endtask
  // Manual trigger of one short recording
  task automatic rec_one;
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0005);
    wait_state(3'h1, 4);
    wait_state(3'h0, 40);
  endtask
  function automatic logic [31:0] status_exp(input int used, input int cnt, input logic [2:0] s);
    return (32'(used) << 12) | (32'(cnt) << 4) | 32'(s);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg(drc_pkg::CTRL_OFS, 32'h0000_0000);
    chk_reg(drc_pkg::MAX_REC_OFS, 32'h0000_0064);
    chk_reg(drc_pkg::PRE_TRIG_OFS, 32'h0000_00C8);
    chk_reg(8'h3C, 32'h0000_0000);
    chk_reg(drc_pkg::STATUS_OFS, 32'h0000_0000);
    // Live channel vector against random source levels
    repeat (8) begin
      @(posedge clk);
      src_level <= 14'($random(seed));
      repeat (3) @(posedge clk);
      chk_reg(drc_pkg::CHAN_OFS, {16'h0000, src_level, 2'b10});
    end
    @(posedge clk);
    src_level <= 14'h0000;
    bus_wr(drc_pkg::PRE_TRIG_OFS, 32'h0000_0000);
    bus_wr(drc_pkg::REC_LEN_OFS, 32'h0000_0001);
    // Manual trigger while disabled
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0004);
    hold_state(3'h0, 8);
    bus_rd(drc_pkg::CTRL_OFS);
    `CHK("manual bit", 1'b0, rdv[2])
    // Recording with stored event unmasked
    bus_wr(drc_pkg::IRQ_MASK_OFS, 32'h0000_0002);
    rec_one();
    bus_rd(drc_pkg::CTRL_OFS);
    `CHK("manual bit", 1'b0, rdv[2])
    `CHK("irq raised", 1'b1, irq)
    chk_reg(drc_pkg::STATUS_OFS, status_exp(16, 1, 3'h0));
    chk_reg(drc_pkg::IRQ_STAT_OFS, 32'h0000_0003);
    bus_wr(drc_pkg::IRQ_STAT_OFS, 32'h0000_000F);
    repeat (2) @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    bus_wr(drc_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    rec_one();
    `CHK("irq masked", 1'b0, irq)
    // Automatic trigger from one selected general channel
    k = 6 + ($unsigned($random(seed)) % 10);
    bus_wr(drc_pkg::TRIG_SEL_OFS, 32'h1 << k);
    @(posedge clk);
    src_level <= 14'h1 << (((k == 15) ? 6 : k + 1) - 2);
    hold_state(3'h0, 8);
    @(posedge clk);
    src_level <= src_level | (14'h1 << (k - 2));
    wait_state(3'h1, 6);
    wait_state(3'h0, 40);
    @(posedge clk);
    src_level <= 14'h0000;
    hold_state(3'h0, 6);
    bus_wr(drc_pkg::TRIG_SEL_OFS, 32'h0000_0000);
    // Invalid configurations
    bus_wr(drc_pkg::MAX_REC_OFS, 32'h0000_0001);
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0003);
    wait_state(3'h5, 4);
    bus_wr(drc_pkg::MAX_REC_OFS, 32'h0000_0000);
    wait_state(3'h0, 4);
    for (int r = 1; r <= 3; r++) begin
      bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0001);
      wait_state(3'h0, 4);
      bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0009 | (32'(r) << 4));
      wait_state((r == 3) ? 3'h0 : 3'h5, 4);
    end
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0001);
    bus_wr(drc_pkg::IRQ_STAT_OFS, 32'h0000_000F);
    bus_wr(drc_pkg::PRE_TRIG_OFS, 32'h0000_07D0);
    wait_state(3'h5, 4);
    bus_rd(drc_pkg::IRQ_STAT_OFS);
    `CHK("config event", 1'b1, rdv[3])
    bus_wr(drc_pkg::PRE_TRIG_OFS, 32'h0000_03E8);
    wait_state(3'h0, 4);
    bus_wr(drc_pkg::PRE_TRIG_OFS, 32'h0000_0000);
    // Clear the three recordings, then fill memory with large ones
    repeat (3) bus_wr(drc_pkg::CLEAR_IDX_OFS, 32'h0000_0001);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(0, 0, 3'h0));
    bus_wr(drc_pkg::REC_SIZE_OFS, 32'h0000_0400);
    repeat (3) rec_one();
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0005);
    wait_state(3'h1, 4);
    wait_state(3'h4, 40);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(4096, 4, 3'h4));
    bus_wr(drc_pkg::CLEAR_IDX_OFS, 32'h0000_0000);
    bus_wr(drc_pkg::CLEAR_IDX_OFS, 32'h0000_0005);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(4096, 4, 3'h4));
    bus_wr(drc_pkg::CLEAR_IDX_OFS, 32'h0000_0001);
    wait_state(3'h0, 4);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(3072, 3, 3'h0));
    repeat (3) bus_wr(drc_pkg::CLEAR_IDX_OFS, 32'h0000_0001);
    // Cap of one hundred small recordings
    bus_wr(drc_pkg::REC_SIZE_OFS, 32'h0000_0010);
    bus_wr(drc_pkg::IRQ_STAT_OFS, 32'h0000_000F);
    repeat (99) rec_one();
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0005);
    wait_state(3'h4, 40);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(1600, 100, 3'h4));
    chk_reg(drc_pkg::IRQ_STAT_OFS, 32'h0000_0007);
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0005);
    hold_state(3'h4, 8);
    // Overwrite mode at the cap drops the oldest
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0003);
    wait_state(3'h0, 4);
    bus_wr(drc_pkg::CTRL_OFS, 32'h0000_0007);
    wait_state(3'h1, 4);
    wait_state(3'h0, 40);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(1600, 100, 3'h0));
    // Reset in mid-run returns the defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("rec_state in reset", 3'h0, rec_state)
    `CHK("irq in reset", 1'b0, irq)
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg(drc_pkg::STATUS_OFS, status_exp(0, 0, 3'h0));
    chk_reg(drc_pkg::CTRL_OFS, 32'h0000_0000);
    wrap_up();
  end
endmodule // testbench
